// file: design/gsbt_pkg.sv
// Purpose: shared constants and types for the gated sixteen bit timer
// Assumes: 32-bit apb data, one word per register
// Notes:   byte addresses below are the apb paddr values
package gsbt_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] GSBT_ADDR_CTRL  = 8'h00;
    localparam logic [7:0] GSBT_ADDR_GATE  = 8'h04;
    localparam logic [7:0] GSBT_ADDR_CNTL  = 8'h08;
    localparam logic [7:0] GSBT_ADDR_CNTH  = 8'h0c;
    localparam logic [7:0] GSBT_ADDR_STAT  = 8'h10;
    localparam logic [7:0] GSBT_ADDR_MASK  = 8'h14;

    // ------------------------------------------------------------
    // counter_control_reg fields
    // ------------------------------------------------------------
    localparam int GSBT_CTRL_ON_BIT     = 0;
    localparam int GSBT_CTRL_ASYNC_BIT  = 2;
    localparam int GSBT_CTRL_PS_LSB     = 4;
    localparam int GSBT_CTRL_CS_LSB     = 6;

    // ------------------------------------------------------------
    // gate_control_reg fields
    // ------------------------------------------------------------
    localparam int GSBT_GATE_VAL_BIT    = 2;
    localparam int GSBT_GATE_POL_BIT    = 6;
    localparam int GSBT_GATE_EN_BIT     = 7;

    // ------------------------------------------------------------
    // status and mask fields
    // ------------------------------------------------------------
    localparam int GSBT_STAT_ROLL_BIT   = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] GSBT_COUNT_RST = 16'h0000;
    localparam logic [15:0] GSBT_COUNT_MAX = 16'hffff;
    localparam logic [1:0]  GSBT_INSTR_DIV = 2'h3;
    localparam logic        GSBT_STAT_RST  = 1'h0;
    localparam logic        GSBT_MASK_RST  = 1'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GSBT_SRC_INSTR = 2'b00,
        GSBT_SRC_SYS   = 2'b01,
        GSBT_SRC_EXT   = 2'b10,
        GSBT_SRC_RSVD  = 2'b11
    } gsbt_src_e;

    typedef struct packed {
        gsbt_src_e  clock_source_select;
        logic [1:0] prescale_select;
        logic       async_select;
        logic       counter_on;
    } gsbt_ctrl_s;

    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
    } gsbt_gate_s;

    localparam gsbt_ctrl_s GSBT_CTRL_RST = '{GSBT_SRC_INSTR, 2'h0, 1'h0, 1'h0};
    localparam gsbt_gate_s GSBT_GATE_RST = '{1'h0, 1'h0};

endpackage : gsbt_pkg

// file: design/gsbt_timer.sv
// Purpose: gated sixteen bit up-counter with apb register access
// Assumes: single clock pclk at 125 MHz, async active low presetn
// Notes:   pins pass three flops; sleep is an input from the core
//
// Overview of operation
// - sixteen bit counter, byte writes replace live bytes
// - on and gate enable decide counting
// - source field picks system, instruction, external clock
// - internal source counts prescaled internal ticks
// - external source counts prescaled pin rising edges
// - external rising edge needs preceding falling edge
// - prescaler divides by one, two, four, eight
// - prescaler hidden, cleared by count byte write
// - async select bypasses prescaled output synchroniser
// - async external counts in sleep, overflow interrupts
// - mode switch may lose or add one count
// - byte reads always return a valid value
// - gate enable and polarity bits control gating
// - gate inactive holds count, active lets count
// - count when gate level equals polarity bit
// - wrap ffff to zero sets rollover flag
`timescale 1ns/10ps
`default_nettype none

module gsbt_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        external_clock_pin,
    input  wire logic        gate_input,
    input  wire logic        proc_sleep,
    output var  logic        irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    gsbt_pkg::gsbt_ctrl_s ctrl;
    gsbt_pkg::gsbt_gate_s gate;
    logic [15:0]          count;
    logic                 rollover_flag;
    logic                 rollover_mask;
    logic [2:0]           ext_pipe;
    logic                 ext_lvl;
    logic [2:0]           gate_pipe;
    logic                 gate_lvl;
    logic                 ext_armed;
    logic [1:0]           instr_cnt;
    logic [2:0]           presc_cnt;
    logic                 sync_d1;
    logic                 sync_d2;
    logic                 apb_access;
    logic                 apb_commit;
    logic                 wr_commit;
    logic                 wr_cntl;
    logic                 wr_cnth;
    logic                 count_written;
    logic                 gate_ok;
    logic                 run;
    logic                 ext_rise;
    logic                 ext_fall;
    logic                 ext_sel;
    logic                 src_tick;
    logic                 presc_tick;
    logic                 inc;
    logic                 overflow;
    logic [31:0]          next_prdata;
    logic                 next_pslverr;
    logic                 wr_ctrl;
    logic                 wr_gate;
    logic                 wr_stat;
    logic                 wr_mask;
    logic                 flag_clear;
    logic                 ext_settled;
    logic                 gate_settled;
    logic                 irq_src;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] b);
        addr_hit = (a == b);
    endfunction : addr_hit

    function automatic logic [2:0] presc_mask(input logic [1:0] ps);
        case (ps)
            2'h0:    presc_mask = 3'h0;
            2'h1:    presc_mask = 3'h1;
            2'h2:    presc_mask = 3'h3;
            default: presc_mask = 3'h7;
        endcase
    endfunction : presc_mask

    function automatic logic pin_settled(input logic [2:0] p);
        pin_settled = (p[1] == p[2]);
    endfunction : pin_settled

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    assign apb_access = psel & penable;
    assign apb_commit = apb_access & pready;
    assign wr_commit  = apb_commit & pwrite;
    assign wr_cntl    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_CNTL);
    assign wr_cnth    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_CNTH);
    assign count_written = wr_cntl | wr_cnth;

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    assign wr_ctrl    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_CTRL);
    assign wr_gate    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_GATE);
    assign wr_stat    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_STAT);
    assign wr_mask    = wr_commit & addr_hit(paddr, gsbt_pkg::GSBT_ADDR_MASK);
    assign flag_clear = wr_stat & pwdata[gsbt_pkg::GSBT_STAT_ROLL_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_access & ~pready;
        end
    end

    // ------------------------------------------------------------
    // read mux and error decode
    // ------------------------------------------------------------
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            gsbt_pkg::GSBT_ADDR_CTRL: begin
                next_prdata[gsbt_pkg::GSBT_CTRL_ON_BIT]    = ctrl.counter_on;
                next_prdata[gsbt_pkg::GSBT_CTRL_ASYNC_BIT] = ctrl.async_select;
                next_prdata[gsbt_pkg::GSBT_CTRL_PS_LSB +: 2] = ctrl.prescale_select;
                next_prdata[gsbt_pkg::GSBT_CTRL_CS_LSB +: 2] = ctrl.clock_source_select;
            end
            gsbt_pkg::GSBT_ADDR_GATE: begin
                next_prdata[gsbt_pkg::GSBT_GATE_EN_BIT]  = gate.gate_enable;
                next_prdata[gsbt_pkg::GSBT_GATE_POL_BIT] = gate.gate_polarity;
                next_prdata[gsbt_pkg::GSBT_GATE_VAL_BIT] = gate_lvl;
            end
            gsbt_pkg::GSBT_ADDR_CNTL: begin
                next_prdata[7:0] = count[7:0];
            end
            gsbt_pkg::GSBT_ADDR_CNTH: begin
                next_prdata[7:0] = count[15:8];
            end
            gsbt_pkg::GSBT_ADDR_STAT: begin
                next_prdata[gsbt_pkg::GSBT_STAT_ROLL_BIT] = rollover_flag;
            end
            gsbt_pkg::GSBT_ADDR_MASK: begin
                next_prdata[gsbt_pkg::GSBT_STAT_ROLL_BIT] = rollover_mask;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_access & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= gsbt_pkg::GSBT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl.counter_on   <= pwdata[gsbt_pkg::GSBT_CTRL_ON_BIT];
            ctrl.async_select <= pwdata[gsbt_pkg::GSBT_CTRL_ASYNC_BIT];
            ctrl.prescale_select <= pwdata[gsbt_pkg::GSBT_CTRL_PS_LSB +: 2];
            ctrl.clock_source_select <=
                gsbt_pkg::gsbt_src_e'(pwdata[gsbt_pkg::GSBT_CTRL_CS_LSB +: 2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= gsbt_pkg::GSBT_GATE_RST;
        end else if (wr_gate) begin
            gate.gate_enable   <= pwdata[gsbt_pkg::GSBT_GATE_EN_BIT];
            gate.gate_polarity <= pwdata[gsbt_pkg::GSBT_GATE_POL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_mask <= gsbt_pkg::GSBT_MASK_RST;
        end else if (wr_mask) begin
            rollover_mask <= pwdata[gsbt_pkg::GSBT_STAT_ROLL_BIT];
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pipe  <= 3'h0;
            gate_pipe <= 3'h0;
        end else begin
            ext_pipe  <= {ext_pipe[1:0], external_clock_pin};
            gate_pipe <= {gate_pipe[1:0], gate_input};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_lvl  <= 1'b0;
            gate_lvl <= 1'b0;
        end else begin
            if (ext_settled) begin
                ext_lvl <= ext_pipe[2];
            end
            if (gate_settled) begin
                gate_lvl <= gate_pipe[2];
            end
        end
    end

    // ------------------------------------------------------------
    // pin edge events
    // ------------------------------------------------------------
    assign ext_settled  = pin_settled(ext_pipe);
    assign gate_settled = pin_settled(gate_pipe);
    assign ext_rise     = ext_settled & ext_pipe[2] & ~ext_lvl;
    assign ext_fall     = ext_settled & ~ext_pipe[2] & ext_lvl;

    // ------------------------------------------------------------
    // enable decode
    // ------------------------------------------------------------
    assign gate_ok = ~gate.gate_enable
                   | (gate_lvl == gate.gate_polarity);
    assign ext_sel = (ctrl.clock_source_select == gsbt_pkg::GSBT_SRC_EXT);
    assign run     = ctrl.counter_on & gate_ok
                   & (~proc_sleep | (ext_sel & ctrl.async_select));

    // ------------------------------------------------------------
    // first edge arming for external counting
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_armed <= 1'b0;
        end else if (~ctrl.counter_on | count_written) begin
            ext_armed <= 1'b0;
        end else if (ext_fall) begin
            ext_armed <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // instruction clock divider
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_cnt <= 2'h0;
        end else begin
            instr_cnt <= instr_cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // source tick selection
    // ------------------------------------------------------------
    always_comb begin
        case (ctrl.clock_source_select)
            gsbt_pkg::GSBT_SRC_SYS:   src_tick = 1'b1;
            gsbt_pkg::GSBT_SRC_INSTR: src_tick = (instr_cnt == gsbt_pkg::GSBT_INSTR_DIV);
            gsbt_pkg::GSBT_SRC_EXT:   src_tick = ext_rise & ext_armed;
            default:                  src_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    assign presc_tick = run & src_tick
                      & ((presc_cnt & presc_mask(ctrl.prescale_select))
                         == presc_mask(ctrl.prescale_select));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt <= 3'h0;
        end else if (count_written) begin
            presc_cnt <= 3'h0;
        end else if (run & src_tick) begin
            presc_cnt <= presc_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // prescaled external clock synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d1 <= 1'b0;
            sync_d2 <= 1'b0;
        end else begin
            sync_d1 <= presc_tick & ext_sel & ~ctrl.async_select;
            sync_d2 <= sync_d1;
        end
    end

    // mode switches may drop or repeat one in-flight tick
    assign inc = ~count_written
               & ((presc_tick & ~(ext_sel & ~ctrl.async_select))
                  | (sync_d2 & ctrl.counter_on));
    assign overflow = inc & (count == gsbt_pkg::GSBT_COUNT_MAX);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= gsbt_pkg::GSBT_COUNT_RST;
        end else if (wr_cntl) begin
            count[7:0] <= pwdata[7:0];
        end else if (wr_cnth) begin
            count[15:8] <= pwdata[7:0];
        end else if (inc) begin
            count <= count + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // rollover flag and interrupt
    // ------------------------------------------------------------
    // set wins over a same cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_flag <= gsbt_pkg::GSBT_STAT_RST;
        end else if (overflow) begin
            rollover_flag <= 1'b1;
        end else if (flag_clear) begin
            rollover_flag <= 1'b0;
        end
    end

    assign irq_src = (rollover_flag | overflow) & rollover_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_src;
        end
    end

endmodule : gsbt_timer

`default_nettype wire

// file: sim/gsbt_timer_asserts.sv
// Purpose: port assertions for gsbt_timer
// Assumes: single pclk domain, presetn async low
// Notes:   bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module gsbt_timer_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_clock_pin,
    input wire logic        gate_input,
    input wire logic        proc_sleep,
    input wire logic        irq
);
    // ----
    // helpers
    // ----
    logic       mapped;
    logic       gate_q;
    logic [2:0] gate_age;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h14);
    // cycles the gate pin has been steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q   <= 1'b0;
            gate_age <= 3'h0;
        end else begin
            gate_q   <= gate_input;
            gate_age <= (gate_input != gate_q) ? 3'h0 : gate_age + 3'(gate_age != 3'h7);
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    err_ready_a: assert property (pslverr |-> pready && !mapped)
        else $error("error without unmapped answer");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    mask_irq_a: assert property (pready && pwrite && paddr == gsbt_pkg::GSBT_ADDR_MASK
        && !pwdata[0] |-> ##2 !irq) else $error("irq high while masked");
    gate_level_a: assert property (pready && !pwrite && paddr == gsbt_pkg::GSBT_ADDR_GATE
        && gate_age == 3'h7 |-> prdata[2] == gate_input) else $error("gate level wrong");
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (pready && paddr == gsbt_pkg::GSBT_ADDR_CNTH);
endmodule : gsbt_timer_asserts
`default_nettype wire

// file: sim/gsbt_pin_model.sv
// Purpose: far side model, count pin and gate pin
// Assumes: tasks called at pclk rising edges
// Notes:   count pin stands still outside bursts
`timescale 1ns/10ps
`default_nettype none
module gsbt_pin_model (
    input  wire logic pclk,
    output var  logic clk_pin,
    output var  logic gate_pin
);
    initial begin
        clk_pin  = 1'b0;
        gate_pin = 1'b0;
    end
    // levels held between bursts
    task automatic set_pins(input logic c, input logic g);
        clk_pin  <= c;
        gate_pin <= g;
    endtask : set_pins
    // n toggles, h pclk cycles per level
    task automatic burst(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge pclk);
            clk_pin <= ~clk_pin;
        end
    endtask : burst
endmodule : gsbt_pin_model
`default_nettype wire

// file: sim/gsbt_timer_test.sv
// Purpose: self-checking bench for gsbt_timer
// Assumes: apb slave answers after one wait state
// Notes:   pins come from gsbt_pin_model
`timescale 1ns/10ps
`default_nettype none
module gsbt_timer_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic        gate_pin;
    logic        proc_sleep;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] cnt;
    logic [1:0]  src;
    int          error_cnt;
    int          n_compared;
    gsbt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_pin(ext_pin), .gate_input(gate_pin),
        .proc_sleep(proc_sleep), .irq(irq));
    gsbt_pin_model u_pin (.pclk(pclk), .clk_pin(ext_pin), .gate_pin(gate_pin));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----
    // tasks
    // ----
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) error_cnt++;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // count compare, one count of slack unless zero
    task automatic chk_near(input string nm, input int e, input logic [15:0] g);
        int d;
        d = int'(g) - e;
        n_compared++;
        if ($isunknown(g) || d * d > int'(e != 0)) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %h", nm, e, g);
        end
    endtask : chk_near
    task automatic rd_cnt();
        apb(1'b0, gsbt_pkg::GSBT_ADDR_CNTL, 32'h0);
        cnt[7:0] = rdat[7:0];
        apb(1'b0, gsbt_pkg::GSBT_ADDR_CNTH, 32'h0);
        cnt[15:8] = rdat[7:0];
    endtask : rd_cnt
    // counter is always off here
    task automatic set_cnt(input logic [15:0] v);
        apb(1'b1, gsbt_pkg::GSBT_ADDR_CNTL, {24'h5a5a5a, v[7:0]});
        apb(1'b1, gsbt_pkg::GSBT_ADDR_CNTH, {24'ha5a5a5, v[15:8]});
    endtask : set_cnt
    task automatic run(input logic [7:0] c, input logic [7:0] g, input logic [15:0] v,
                       input int tg, input int n);
        set_cnt(v);
        apb(1'b1, gsbt_pkg::GSBT_ADDR_GATE, {24'h0, g});
        apb(1'b1, gsbt_pkg::GSBT_ADDR_CTRL, {24'h0, c});
        if (tg > 0) u_pin.burst(tg, 4);
        repeat (n) @(posedge pclk);
        apb(1'b1, gsbt_pkg::GSBT_ADDR_CTRL, {24'h0, c[7:1], 1'b0});
        rd_cnt();
    endtask : run
    task automatic ext(input logic [7:0] c, input logic l, input int tg, input int e);
        u_pin.set_pins(l, 1'b0);
        run(c, 8'h0, 16'h0, tg, 8);
        chk("pin count", 32'(e), {16'h0, cnt});
    endtask : ext
    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // ----
    // tests
    // ----
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, proc_sleep} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, rdat);
        end
        apb(1'b1, 8'h18, 32'hff);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        set_cnt(16'ha5c3);
        rd_cnt();
        chk("count bytes", 32'ha5c3, {16'h0, cnt});
        for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 4; p++) begin
                src = (s == 2) ? 2'h3 : 2'(s);
                run({src, 2'(p), 4'h1}, 8'h0, 16'h0, 0, 200);
                chk_near("timer count", (s == 1) ? 204 >> p : (s == 0) ? 51 >> p : 0, cnt);
            end
        end
        for (int g = 0; g < 2; g++) begin
            for (int p = 0; p < 2; p++) begin
                u_pin.set_pins(1'b0, 1'(g));
                run(8'h41, {1'b1, 1'(p), 6'h0}, 16'h0, 0, 200);
                chk_near("gated count", (g == p) ? 204 : 0, cnt);
                apb(1'b0, gsbt_pkg::GSBT_ADDR_GATE, 32'h0);
                chk("gate reg", {24'h0, 1'b1, 1'(p), 3'h0, 1'(g), 2'h0}, rdat);
            end
        end
        run(8'h40, 8'h80, 16'h0, 0, 200);
        chk_near("off count", 0, cnt);
        ext(8'h81, 1'b1, 8, 4);
        ext(8'h81, 1'b0, 8, 3);
        ext(8'h85, 1'b1, 8, 4);
        ext(8'h91, 1'b1, 16, 4);
        proc_sleep <= 1'b1;
        run(8'h41, 8'h0, 16'h0, 0, 200);
        chk_near("sleep count", 0, cnt);
        apb(1'b1, gsbt_pkg::GSBT_ADDR_MASK, 32'h1);
        u_pin.set_pins(1'b1, 1'b0);
        run(8'h85, 8'h0, 16'hfffe, 4, 8);
        chk("wrapped count", 32'h0, {16'h0, cnt});
        chk("irq raised", 32'h1, {31'h0, irq});
        proc_sleep <= 1'b0;
        apb(1'b0, gsbt_pkg::GSBT_ADDR_STAT, 32'h0);
        chk("rollover flag", 32'h1, rdat);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, (k == 2) ? gsbt_pkg::GSBT_ADDR_STAT : gsbt_pkg::GSBT_ADDR_MASK, 32'(k != 0));
            repeat (2) @(posedge pclk);
            chk("irq level", 32'(k == 1), {31'h0, irq});
        end
        apb(1'b0, gsbt_pkg::GSBT_ADDR_STAT, 32'h0);
        chk("flag cleared", 32'h0, rdat);
        complete_run();
    end
endmodule : gsbt_timer_test
bind gsbt_timer gsbt_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_clock_pin(external_clock_pin),
    .gate_input(gate_input), .proc_sleep(proc_sleep), .irq(irq));
`default_nettype wire
